// *** hw/fcd_host.sv ***
// host-side command sequencer driving a banked parallel flash
// assumes the flash pins are sampled synchronously; one op accepted at a time
`timescale 1ns/1ns
module fcd_host (
  input wire logic mclk_i, // 250 MHz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic req_i, // start an operation, one-cycle pulse
  input wire fcd_pkg::fcd_op_e op_i, // operation to run
  input wire logic [fcd_pkg::ADDR_W-1:0] addr_i, // target/sector/bank address
  input wire logic [fcd_pkg::DATA_W-1:0] wdata_i, // program datum
  output logic busy_o, // operation in progress
  output logic done_o, // operation finished, one-cycle pulse
  output logic [fcd_pkg::DATA_W-1:0] rdata_o, // last read datum
  output logic bypass_o, // bypass mode tracked
  output logic window_o, // sector-add window open
  output logic [fcd_pkg::ADDR_W-1:0] fl_addr_o, // flash address
  output logic [fcd_pkg::DATA_W-1:0] fl_dq_o, // flash data out
  output logic fl_dq_oe_o, // flash data drive enable
  input wire logic [fcd_pkg::DATA_W-1:0] fl_dq_i, // flash data in
  output logic fl_ce_n_o, // chip enable, active low
  output logic fl_we_n_o, // write enable, active low
  output logic fl_oe_n_o, // output enable, active low
  output logic fl_rst_n_o // hardware reset, active low
);
  import fcd_pkg::*;

  // ****************************************************************
  // state and sequence storage
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_PULSE = 3'b010,
    ST_HOLD = 3'b011, ST_DONE = 3'b100
  } fcd_state_e;

  fcd_state_e state_ff; // bus phase
  logic [2:0] cyc_ff; // current cycle index in sequence
  logic [2:0] ncyc_ff; // number of cycles in sequence
  logic [7:0] tmr_ff; // phase timer
  logic [31:0] win_ff; // sector-add window counter
  logic rd_ff; // current cycle is a read
  fcd_op_e op_ff; // latched op
  logic [ADDR_W-1:0] tgt_ff; // latched target
  logic [DATA_W-1:0] dat_ff; // latched datum
  logic [ADDR_W-1:0] seq_a [6]; // per-cycle address
  logic [DATA_W-1:0] seq_d [6]; // per-cycle data
  logic [5:0] seq_r; // per-cycle read flag

  // bank-qualified word offset: bank bits kept, rest replaced
  function automatic logic [ADDR_W-1:0] bq(input logic [ADDR_W-1:0] a,
                                           input logic [11:0] off);
    bq = {a[ADDR_W-1:ADDR_W-3], 7'h00, off};
  endfunction
  // command word: upper byte driven zero, high address zero
  function automatic logic [DATA_W-1:0] cw(input logic [7:0] c);
    cw = {8'h00, c};
  endfunction
  function automatic logic [ADDR_W-1:0] ca(input logic [11:0] off);
    ca = {10'h000, off};
  endfunction

  // ****************************************************************
  // sequence table from the latched op
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      seq_a[i] = ca(ADR_UNLOCK1);
      seq_d[i] = cw(CMD_UNLOCK1);
    end
    seq_a[1] = ca(ADR_UNLOCK2);
    seq_d[1] = cw(CMD_UNLOCK2);
    seq_a[4] = ca(ADR_UNLOCK2);
    seq_d[4] = cw(CMD_UNLOCK2);
    seq_a[2] = ca(ADR_UNLOCK1);
    seq_d[2] = cw(CMD_ID);
    seq_r = 6'b000000;
    case (op_ff)
      OP_READ: begin
        seq_a[0] = tgt_ff;
        seq_r = 6'b000001;
      end
      OP_RESET: begin
        seq_d[0] = cw(CMD_RESET);
      end
      OP_ID: begin
        seq_a[2] = bq(tgt_ff, ADR_UNLOCK1);
      end
      OP_ID_READ: begin
        seq_a[0] = tgt_ff;
        seq_r = 6'b000001;
      end
      OP_SEC_IN: begin
        seq_d[2] = cw(CMD_SECURE);
      end
      OP_SEC_OUT: begin
        seq_d[3] = cw(CMD_ZERO);
      end
      OP_PROG: begin
        if (bypass_o) begin
          seq_d[0] = cw(CMD_PROG);
          seq_a[1] = tgt_ff;
          seq_d[1] = dat_ff;
        end else begin
          seq_d[2] = cw(CMD_PROG);
          seq_a[3] = tgt_ff;
          seq_d[3] = dat_ff;
        end
      end
      OP_BYP_IN: begin
        seq_d[2] = cw(CMD_BYPASS);
      end
      OP_BYP_OUT: begin
        seq_d[0] = cw(CMD_ID);
        seq_d[1] = cw(CMD_ZERO);
      end
      OP_CHIP, OP_SECTOR: begin
        seq_d[2] = cw(CMD_ERASE);
        seq_d[5] = cw(CMD_CHIP);
        if (op_ff == OP_SECTOR) begin
          seq_a[5] = {tgt_ff[ADDR_W-1:12], 12'h000};
          seq_d[5] = cw(CMD_SECTOR);
        end
        if (window_o && op_ff == OP_SECTOR) begin
          seq_a[0] = {tgt_ff[ADDR_W-1:12], 12'h000};
          seq_d[0] = cw(CMD_SECTOR);
        end
      end
      OP_SUSPEND: begin
        seq_a[0] = bq(tgt_ff, 12'h000);
        seq_d[0] = cw(CMD_SUSPEND);
      end
      OP_RESUME: begin
        seq_a[0] = bq(tgt_ff, 12'h000);
        seq_d[0] = cw(CMD_SECTOR);
      end
      OP_QUERY: begin
        seq_a[0] = ca(ADR_QUERY);
        seq_d[0] = cw(CMD_QUERY);
      end
      default: begin
        seq_r = 6'b000000;
      end
    endcase
  end

  // cycle count of the op in the current mode
  function automatic logic [2:0] ncyc(input fcd_op_e o, input logic byp, input logic win);
    case (o)
      // id entry is three writes; its fourth cycle is a separate read op
      OP_SEC_OUT: ncyc = 3'd4;
      OP_PROG: ncyc = byp ? 3'd2 : 3'd4;
      OP_ID, OP_SEC_IN, OP_BYP_IN: ncyc = 3'd3;
      OP_BYP_OUT: ncyc = 3'd2;
      OP_CHIP: ncyc = 3'd6;
      OP_SECTOR: ncyc = win ? 3'd1 : 3'd6;
      default: ncyc = 3'd1;
    endcase
  endfunction

  // ****************************************************************
  // bus phase machine
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cyc_ff <= 3'd0;
      ncyc_ff <= 3'd0;
      tmr_ff <= 8'h00;
      rd_ff <= 1'b0;
      op_ff <= OP_READ;
      tgt_ff <= '0;
      dat_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // a new op is only taken when idle; requests while busy are dropped
          if (req_i) begin
            op_ff <= op_i;
            tgt_ff <= addr_i;
            dat_ff <= wdata_i;
            ncyc_ff <= ncyc(op_i, bypass_o, window_o);
            cyc_ff <= 3'd0;
            tmr_ff <= CY_SETUP;
            state_ff <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          rd_ff <= seq_r[cyc_ff];
          if (tmr_ff <= 8'h01) begin
            tmr_ff <= seq_r[cyc_ff] ? CY_ACC : CY_PULSE;
            state_ff <= ST_PULSE;
          end else begin
            tmr_ff <= tmr_ff - 8'h01;
          end
        end
        ST_PULSE: begin
          if (tmr_ff <= 8'h01) begin
            tmr_ff <= CY_HOLD;
            state_ff <= ST_HOLD;
          end else begin
            tmr_ff <= tmr_ff - 8'h01;
          end
        end
        ST_HOLD: begin
          if (tmr_ff <= 8'h01) begin
            if (cyc_ff + 3'd1 >= ncyc_ff) begin
              state_ff <= ST_DONE;
            end else begin
              cyc_ff <= cyc_ff + 3'd1;
              tmr_ff <= CY_SETUP;
              state_ff <= ST_SETUP;
            end
          end else begin
            tmr_ff <= tmr_ff - 8'h01;
          end
        end
        ST_DONE: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // pin drive: address/data stay stable around the strobe pulse
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fl_addr_o <= '0;
      fl_dq_o <= '0;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o <= 1'b1;
      fl_we_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
      fl_rst_n_o <= 1'b0;
    end else begin
      fl_rst_n_o <= 1'b1;
      fl_addr_o <= seq_a[cyc_ff];
      fl_dq_o <= seq_d[cyc_ff];
      fl_dq_oe_o <= (state_ff != ST_IDLE && state_ff != ST_DONE) && !seq_r[cyc_ff];
      fl_ce_n_o <= !(state_ff == ST_PULSE);
      fl_we_n_o <= !(state_ff == ST_PULSE && !rd_ff);
      fl_oe_n_o <= !(state_ff == ST_PULSE && rd_ff);
    end
  end

  // ****************************************************************
  // status outputs and read capture
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= '0;
    end else begin
      busy_o <= (state_ff != ST_IDLE) || req_i;
      done_o <= (state_ff == ST_DONE);
      if (state_ff == ST_PULSE && rd_ff && tmr_ff == 8'h01) begin
        rdata_o <= fl_dq_i;
      end
    end
  end

  // mode tracking: bypass and the sector-add window
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bypass_o <= 1'b0;
      window_o <= 1'b0;
      win_ff <= 32'd0;
    end else begin
      if (state_ff == ST_DONE) begin
        if (op_ff == OP_BYP_IN) begin
          bypass_o <= 1'b1;
        end else if (op_ff == OP_BYP_OUT || op_ff == OP_RESET) begin
          bypass_o <= 1'b0;
        end
      end
      if (state_ff == ST_DONE && op_ff == OP_SECTOR) begin
        window_o <= 1'b1;
        win_ff <= 32'(CY_WINDOW);
      end else if (state_ff == ST_SETUP && op_ff != OP_SECTOR && window_o) begin
        window_o <= 1'b0;
      end else if (window_o) begin
        if (win_ff <= 32'd1) begin
          window_o <= 1'b0;
        end
        win_ff <= win_ff - 32'd1;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_we_ce_pair: assert property (@(posedge mclk_i) disable iff (rst_i)
    !fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o) else $error("write strobe without select");
  a_cmd_upper_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!fl_we_n_o && op_ff != OP_PROG) |-> fl_dq_o[15:8] == 8'h00)
    else $error("upper byte set in command");
  a_addr_stable: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!fl_we_n_o && $past(!fl_we_n_o)) |-> $stable(fl_addr_o) && $stable(fl_dq_o))
    else $error("bus changed under strobe");
  a_read_no_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
    !fl_oe_n_o |-> !fl_dq_oe_o) else $error("drive during read");
  a_done_after_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
    done_o |-> $past(busy_o)) else $error("done without busy");
  a_reset_clears: assert property (@(posedge mclk_i)
    rst_i |=> !bypass_o && !window_o && !fl_rst_n_o) else $error("reset left mode");
  a_bypass_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_ff == ST_DONE && op_ff == OP_BYP_IN) |=> bypass_o)
    else $error("bypass not tracked");
  a_window_open: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_ff == ST_DONE && op_ff == OP_SECTOR) |=> window_o)
    else $error("window not opened");
  c_prog: cover property (@(posedge mclk_i) state_ff == ST_DONE && op_ff == OP_PROG);
  c_sector: cover property (@(posedge mclk_i) state_ff == ST_DONE && op_ff == OP_SECTOR);
  c_read: cover property (@(posedge mclk_i) state_ff == ST_DONE && op_ff == OP_READ);
endmodule // fcd_host

// *** hw/fcd_pkg.sv ***
// package for the flash command sequencer (host side)
// assumes a word-addressed 22-bit address and 16-bit data flash bus
package fcd_pkg;
  // ****************************************************************
  // bus widths
  // ****************************************************************
  localparam int ADDR_W = 22; // word address width
  localparam int DATA_W = 16; // data width
  // ****************************************************************
  // command addresses (word mode)
  // ****************************************************************
  localparam logic [11:0] ADR_UNLOCK1 = 12'h555; // first unlock address
  localparam logic [11:0] ADR_UNLOCK2 = 12'h2AA; // second unlock address
  localparam logic [11:0] ADR_QUERY = 12'h055; // query-table entry address
  localparam logic [11:0] ADR_ID_MAKER = 12'h000; // maker code offset
  localparam logic [11:0] ADR_ID_PART1 = 12'h001; // part code, first
  localparam logic [11:0] ADR_ID_PROT = 12'h002; // sector protect offset
  localparam logic [11:0] ADR_ID_LOCK = 12'h003; // secure-sector lock offset
  localparam logic [11:0] ADR_ID_PART2 = 12'h00E; // part code, second
  localparam logic [11:0] ADR_ID_PART3 = 12'h00F; // part code, third
  // ****************************************************************
  // command data bytes
  // ****************************************************************
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA; // first unlock datum
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55; // second unlock datum
  localparam logic [7:0] CMD_RESET = 8'hF0; // return to read
  localparam logic [7:0] CMD_ID = 8'h90; // identification / bypass exit
  localparam logic [7:0] CMD_ZERO = 8'h00; // exit second cycle
  localparam logic [7:0] CMD_PROG = 8'hA0; // program setup
  localparam logic [7:0] CMD_BYPASS = 8'h20; // unlock bypass entry
  localparam logic [7:0] CMD_ERASE = 8'h80; // erase setup
  localparam logic [7:0] CMD_CHIP = 8'h10; // chip erase
  localparam logic [7:0] CMD_SECTOR = 8'h30; // sector erase / resume
  localparam logic [7:0] CMD_SUSPEND = 8'hB0; // erase suspend
  localparam logic [7:0] CMD_SECURE = 8'h88; // secure-sector entry
  localparam logic [7:0] CMD_QUERY = 8'h98; // query entry
  // ****************************************************************
  // host operation codes
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_ID = 4'h2, OP_SEC_IN = 4'h3,
    OP_SEC_OUT = 4'h4, OP_PROG = 4'h5, OP_BYP_IN = 4'h6, OP_BYP_OUT = 4'h7,
    OP_CHIP = 4'h8, OP_SECTOR = 4'h9, OP_SUSPEND = 4'hA, OP_RESUME = 4'hB,
    OP_QUERY = 4'hC, OP_ID_READ = 4'hD
  } fcd_op_e;
  // ****************************************************************
  // bus strobe timing (cycles of 4 ns)
  // ****************************************************************
  localparam int CLK_NS = 4; // clock period
  localparam int T_SETUP_NS = 30; // address/data to strobe low, least
  localparam int T_PULSE_NS = 35; // strobe low width, least
  localparam int T_HOLD_NS = 20; // strobe high recovery, least
  localparam int T_ACC_NS = 70; // read access, least
  localparam logic [7:0] CY_SETUP = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CY_PULSE = 8'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CY_HOLD = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CY_ACC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  // sector-add window; the host must space extra sector writes under it
  localparam int T_WINDOW_US = 80; // sector erase add window
  localparam int CY_WINDOW = T_WINDOW_US * 1000 / CLK_NS; // 20000 cycles
endpackage

// *** test/fcd_flash_model.sv ***
// behavioural flash device answering the host sequencer's pins
// assumes writes end on the strobe rising edge, sampled on mclk_i
`timescale 1ns/1ns
module fcd_flash_model (
  input wire logic mclk_i, // sampling clock
  input wire logic [21:0] fl_addr_i, // flash address
  input wire logic [15:0] fl_dq_i, // data from host
  input wire logic fl_ce_n_i, // chip enable, active low
  input wire logic fl_we_n_i, // write enable, active low
  input wire logic fl_oe_n_i, // output enable, active low
  input wire logic fl_rst_n_i, // hardware reset, active low
  output logic [15:0] fl_dq_o // data to host
);
  parameter logic [15:0] MAKER_CODE = 16'h0033; // arbitrary value
  parameter logic [15:0] PART_A = 16'h0044; // arbitrary value
  parameter logic [15:0] PART_B = 16'h0055; // arbitrary value
  parameter logic [15:0] PART_C = 16'h0066; // arbitrary value
  // ****************************
  // state
  // ****************************
  logic [15:0] mem [256]; // small array image
  logic [21:0] wlog_a [64]; // address of each write
  logic [15:0] wlog_d [64]; // datum of each write
  int wcnt; // writes seen
  logic we_q; // last write strobe
  logic ce_q; // last chip enable; both strobes rise together at the host
  logic [1:0] unl; // unlock cycles seen
  logic id_m, prog_m, byp_m, er_m; // modes
  logic [15:0] rd, last; // read value, last driven
  // ****************************
  // write decode on the strobe rising edge
  // ****************************
  always @(posedge mclk_i) begin
    we_q <= fl_we_n_i;
    ce_q <= fl_ce_n_i;
    if (!fl_rst_n_i) begin
      {unl, id_m, prog_m, byp_m, er_m} <= '0;
      wcnt <= 0;
      for (int i = 0; i < 256; i++) mem[i] <= 16'hFFFF;
    end else if (fl_we_n_i && !we_q && !ce_q) begin
      // datum taken at the first rising strobe edge
      wlog_a[wcnt] <= fl_addr_i;
      wlog_d[wcnt] <= fl_dq_i;
      wcnt <= wcnt + 1;
      if (prog_m) begin
        mem[fl_addr_i[7:0]] <= fl_dq_i;
        prog_m <= 1'b0;
      end else if (fl_dq_i[7:0] == 8'hF0) begin
        {unl, id_m} <= '0;
      end else if (byp_m && fl_dq_i[7:0] == 8'hA0) begin
        prog_m <= 1'b1;
      end else if (unl == 0 && fl_addr_i[11:0] == 12'h555 && fl_dq_i[7:0] == 8'hAA) begin
        unl <= 2'd1;
      end else if (unl == 1 && fl_addr_i[11:0] == 12'h2AA && fl_dq_i[7:0] == 8'h55) begin
        unl <= 2'd2;
      end else if (unl == 2) begin
        unl <= 2'd0;
        case (fl_dq_i[7:0])
          8'h90: id_m <= 1'b1;
          8'hA0: prog_m <= 1'b1;
          8'h20: byp_m <= 1'b1;
          8'h80: er_m <= 1'b1;
          8'h10: if (er_m) for (int i = 0; i < 256; i++) mem[i] <= 16'h0000;
          default: ;
        endcase
      end else begin
        unl <= 2'd0;
        if (fl_dq_i[7:0] == 8'h00) byp_m <= 1'b0;
      end
    end
  end
  // ****************************
  // read path; a released bus shows the inverse of its last value
  // ****************************
  always_comb begin
    rd = mem[fl_addr_i[7:0]];
    if (id_m) begin
      case (fl_addr_i[7:0])
        8'h00: rd = MAKER_CODE;
        8'h01: rd = PART_A;
        8'h0E: rd = PART_B;
        8'h0F: rd = PART_C;
        8'h03: rd = 16'h0040;
        8'h02: rd = 16'h0001;
        default: rd = 16'h0000;
      endcase
    end
  end
  // remember only what was really driven, so a released bus shows its inverse
  always @(posedge mclk_i) begin
    if (!fl_ce_n_i && !fl_oe_n_i) last <= rd;
  end
  assign fl_dq_o = (!fl_ce_n_i && !fl_oe_n_i) ? rd : ~last;
endmodule // fcd_flash_model

// *** test/tb.sv ***
// self-checking bench for the host-side flash command sequencer
// assumes the flash model logs each write cycle it sees
`timescale 1ns/1ns
module tb;
  import fcd_pkg::*;
  logic mclk_i = 0, rst_i = 1, req_i = 0;
  fcd_op_e op_i = OP_READ;
  logic [21:0] addr_i = '0, fl_addr_o;
  logic [15:0] wdata_i = '0, rdata_o, fl_dq_o, fl_dq_i;
  logic busy_o, done_o, bypass_o, window_o, fl_dq_oe_o;
  logic fl_ce_n_o, fl_we_n_o, fl_oe_n_o, fl_rst_n_o;
  int failures = 0, cmp_count = 0, ptr = 0;
  fcd_host u_fcd_host (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .op_i(op_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o), .bypass_o(bypass_o), .window_o(window_o), .fl_addr_o(fl_addr_o),
    .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_dq_i(fl_dq_i), .fl_ce_n_o(fl_ce_n_o),
    .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_rst_n_o(fl_rst_n_o));
  fcd_flash_model u_fcd_flash_model (.mclk_i(mclk_i), .fl_addr_i(fl_addr_o),
    .fl_dq_i(fl_dq_o), .fl_ce_n_i(fl_ce_n_o), .fl_we_n_i(fl_we_n_o), .fl_oe_n_i(fl_oe_n_o),
    .fl_rst_n_i(fl_rst_n_o), .fl_dq_o(fl_dq_i));
  initial forever #2 mclk_i = ~mclk_i;
  // ****************************
  // helpers
  // ****************************
  task automatic test_done();
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one operation, bounded wait for done
  task automatic run(input fcd_op_e op, input logic [21:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    req_i <= 1'b1;
    op_i <= op;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    req_i <= 1'b0;
    for (int i = 0; i <= 4000; i++) begin
      @(posedge mclk_i);
      if (done_o === 1'b1) break;
      if (i == 4000) begin
        failures++;
        test_done();
      end
    end
    @(negedge mclk_i);
    check(busy_o, 1'b0);
  endtask
  // next logged write: low address bits and a command byte with zero upper byte
  task automatic exp_w(input logic [11:0] a, input logic [7:0] d);
    check(u_fcd_flash_model.wlog_a[ptr][11:0], a);
    check(u_fcd_flash_model.wlog_d[ptr], {8'h00, d});
    ptr++;
  endtask
  task automatic unlock();
    exp_w(12'h555, 8'hAA);
    exp_w(12'h2AA, 8'h55);
  endtask
  // ****************************
  // scenarios
  // ****************************
  task automatic t_prog();
    run(OP_PROG, 22'h3A0012, 16'hA5C3);
    unlock();
    exp_w(12'h555, 8'hA0);
    check(u_fcd_flash_model.wlog_a[ptr], 22'h3A0012);
    check(u_fcd_flash_model.wlog_d[ptr], 16'hA5C3);
    ptr++;
    run(OP_READ, 22'h3A0012, 16'h0000);
    check(rdata_o, 16'hA5C3);
    check(ptr, u_fcd_flash_model.wcnt);
  endtask
  task automatic t_bypass();
    run(OP_BYP_IN, 22'h000000, 16'h0000);
    unlock();
    exp_w(12'h555, 8'h20);
    check(bypass_o, 1'b1);
    run(OP_PROG, 22'h000021, 16'h5AA5);
    exp_w(u_fcd_flash_model.wlog_a[ptr][11:0], 8'hA0);
    check(u_fcd_flash_model.wlog_a[ptr], 22'h000021);
    check(u_fcd_flash_model.wlog_d[ptr], 16'h5AA5);
    ptr++;
    run(OP_READ, 22'h000021, 16'h0000);
    check(rdata_o, 16'h5AA5);
    run(OP_BYP_OUT, 22'h000000, 16'h0000);
    exp_w(u_fcd_flash_model.wlog_a[ptr][11:0], 8'h90);
    exp_w(u_fcd_flash_model.wlog_a[ptr][11:0], 8'h00);
    check(bypass_o, 1'b0);
  endtask
  task automatic t_id();
    logic [11:0] offs [6] = '{12'h000, 12'h001, 12'h00E, 12'h00F, 12'h003, 12'h002};
    logic [15:0] vals [6] = '{16'h0033, 16'h0044, 16'h0055, 16'h0066, 16'h0040, 16'h0001};
    run(OP_ID, 22'h200000, 16'h0000);
    unlock();
    check(u_fcd_flash_model.wlog_a[ptr], 22'h200555);
    exp_w(12'h555, 8'h90);
    for (int i = 0; i < 6; i++) begin
      run(OP_ID_READ, 22'h200000 | 22'(offs[i]), 16'h0000);
      check(rdata_o, vals[i]);
    end
    run(OP_QUERY, 22'h000000, 16'h0000);
    exp_w(12'h055, 8'h98);
    run(OP_RESET, 22'h000000, 16'h0000);
    exp_w(u_fcd_flash_model.wlog_a[ptr][11:0], 8'hF0);
    run(OP_READ, 22'h000021, 16'h0000);
    check(rdata_o, 16'h5AA5);
  endtask
  task automatic t_erase();
    run(OP_SECTOR, 22'h123000, 16'h0000);
    unlock();
    exp_w(12'h555, 8'h80);
    unlock();
    check(u_fcd_flash_model.wlog_a[ptr][21:12], 10'h123);
    exp_w(12'h000, 8'h30);
    check(window_o, 1'b1);
    run(OP_SECTOR, 22'h1C5000, 16'h0000);
    check(u_fcd_flash_model.wlog_a[ptr][21:12], 10'h1C5);
    exp_w(12'h000, 8'h30);
    run(OP_SUSPEND, 22'h180000, 16'h0000);
    check(u_fcd_flash_model.wlog_a[ptr][21:19], 3'h3);
    exp_w(u_fcd_flash_model.wlog_a[ptr][11:0], 8'hB0);
    check(window_o, 1'b0);
    run(OP_READ, 22'h000021, 16'h0000);
    check(rdata_o, 16'h5AA5);
    run(OP_RESUME, 22'h180000, 16'h0000);
    check(u_fcd_flash_model.wlog_a[ptr][21:19], 3'h3);
    exp_w(u_fcd_flash_model.wlog_a[ptr][11:0], 8'h30);
    run(OP_SECTOR, 22'h0C7000, 16'h0000);
    unlock();
    exp_w(12'h555, 8'h80);
    unlock();
    check(u_fcd_flash_model.wlog_a[ptr][21:12], 10'h0C7);
    exp_w(12'h000, 8'h30);
    check(window_o, 1'b1);
    run(OP_RESET, 22'h000000, 16'h0000);
    check(window_o, 1'b0);
    exp_w(u_fcd_flash_model.wlog_a[ptr][11:0], 8'hF0);
    run(OP_CHIP, 22'h000000, 16'h0000);
    unlock();
    exp_w(12'h555, 8'h80);
    unlock();
    exp_w(12'h555, 8'h10);
    run(OP_READ, 22'h000021, 16'h0000);
    check(rdata_o, 16'h0000);
  endtask
  task automatic t_secure();
    run(OP_SEC_IN, 22'h000000, 16'h0000);
    unlock();
    exp_w(12'h555, 8'h88);
    run(OP_SEC_OUT, 22'h000000, 16'h0000);
    unlock();
    exp_w(12'h555, 8'h90);
    exp_w(u_fcd_flash_model.wlog_a[ptr][11:0], 8'h00);
  endtask
  task automatic t_hwreset();
    run(OP_BYP_IN, 22'h000000, 16'h0000);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    check(fl_rst_n_o, 1'b0);
    check(bypass_o, 1'b0);
    @(posedge mclk_i);
    rst_i <= 1'b0;
    ptr = 0;
    run(OP_PROG, 22'h000005, 16'h1234);
    unlock();
    exp_w(12'h555, 8'hA0);
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_prog();
    t_bypass();
    t_id();
    t_erase();
    t_secure();
    t_hwreset();
    test_done();
  end
endmodule // tb
